/* hw/icu_top.sv */
`timescale 1ns/1ps
`include "icu_cfg.svh"

module icu_top (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire icu_pkg::icu_word_t hwdata_in,
    input wire logic hready_in,
    output icu_pkg::icu_word_t hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic fetch_valid_in,
    input wire logic [31:0] fetch_addr_in,
    input wire logic fetch_abort_in,
    output logic hit_ready_out,
    output icu_pkg::icu_word_t instr_out,
    input wire logic pbus_done_in,
    input wire icu_pkg::icu_word_t pbus_data_in,
    output logic lf_req_out,
    output logic [31:0] lf_addr_out,
    input wire logic lf_word_valid_in,
    input wire icu_pkg::icu_word_t lf_word_in,
    input wire logic dbg_wr_in,
    input wire logic [31:0] dbg_addr_in,
    input wire icu_pkg::icu_word_t dbg_data_in,
    input wire logic dbg_lock_in,
    input wire logic move_to_special_wr_in,
    input wire icu_pkg::icu_word_t move_to_special_data_in,
    output icu_pkg::icu_word_t machine_status_word_out
);
    import icu_pkg::*;

    // ----------------------------------------
    // geometry
    // ----------------------------------------
    localparam int WIDX_W = `ICU_WIDX_W;
    localparam int BIDX_W = WIDX_W + 2;
    localparam int TAG_W = `ICU_SPAN_W - BIDX_W;
    localparam int LW = `ICU_LINK_SEL ? 2 : 0;

    icu_state_t state_q;
    icu_word_t msw_q;
    icu_word_t waddr_q;
    icu_word_t wdata_q;
    icu_word_t hits_q;
    logic [31:0] req_addr_q;
    logic first_q;
    logic [2:0] fill_cnt_q;
    logic hit_ready_q;
    icu_word_t instr_q;
    logic lf_req_q;
    logic op_go;
    logic op_lock;
    logic ph_sel_q;
    logic ph_write_q;
    logic [7:0] ph_addr_q;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    logic cache_en;
    logic in_window;
    logic in_local;
    logic cacheable;
    logic [31:0] offs;
    logic [TAG_W-1:0] req_tag;
    logic [WIDX_W-1:0] req_idx;
    logic [31:0] miss_offs;
    logic [TAG_W-1:0] miss_tag;
    logic [WIDX_W-1:0] miss_idx;
    logic [WIDX_W-1:0] fill_idx;

    assign cache_en = msw_q[`ICU_EN_BIT];
    assign in_window = (fetch_addr_in >= `ICU_LOW_BOUND)
                    && (fetch_addr_in <= `ICU_HIGH_BOUND);
    assign in_local = (fetch_addr_in >= `ICU_LOCAL_LOW)
                   && (fetch_addr_in <= `ICU_LOCAL_HIGH);
    // the gated enable keeps disabled fetches from hitting or starting a refill; their tag is still read
    assign cacheable = `ICU_PRESENT && cache_en && in_window && !in_local;
    assign offs = fetch_addr_in - `ICU_LOW_BOUND;
    assign req_tag = offs[`ICU_SPAN_W-1:BIDX_W];
    assign req_idx = offs[BIDX_W-1:2];
    assign miss_offs = req_addr_q - `ICU_LOW_BOUND;
    assign miss_tag = miss_offs[`ICU_SPAN_W-1:BIDX_W];
    assign miss_idx = miss_offs[BIDX_W-1:2];
    // burst wraps inside its own line so the critical word may sit anywhere in it
    assign fill_idx = {miss_idx[WIDX_W-1:2], miss_idx[1:0] + fill_cnt_q[1:0]};

    // ----------------------------------------
    // storage
    // ----------------------------------------
    icu_word_t rd_data;
    logic [TAG_W-1:0] rd_tag;
    logic rd_valid;
    logic rd_lock;
    logic lookup_hit;
    logic refill_we;
    logic we;
    logic [WIDX_W-1:0] wr_idx;
    logic [WIDX_W-1:0] rd_idx;
    icu_word_t wr_data;
    logic [TAG_W-1:0] wr_tag;
    logic wr_lock;
    logic [31:0] dbg_offs;
    logic [31:0] sw_offs;

    assign rd_idx = (state_q == ICU_IDLE) ? req_idx : miss_idx;
    assign lookup_hit = rd_valid && (rd_tag == req_tag);
    assign dbg_offs = dbg_addr_in - `ICU_LOW_BOUND;
    assign sw_offs = waddr_q - `ICU_LOW_BOUND;

    // refill only into an unlocked line; locked code stays resident
    assign refill_we = (((state_q == ICU_BUS) && pbus_done_in)
                     || ((state_q == ICU_FILL) && lf_word_valid_in))
                     && !rd_lock;
    assign we = dbg_wr_in || op_go || refill_we;

    // debug wins over the software op, which wins over refill
    always_comb begin
        if (dbg_wr_in) begin
            wr_idx = dbg_offs[BIDX_W-1:2];
            wr_tag = dbg_offs[`ICU_SPAN_W-1:BIDX_W];
            wr_data = dbg_data_in;
            wr_lock = dbg_lock_in;
        end else if (op_go) begin
            wr_idx = sw_offs[BIDX_W-1:2];
            wr_tag = sw_offs[`ICU_SPAN_W-1:BIDX_W];
            wr_data = wdata_q;
            wr_lock = op_lock;
        end else begin
            wr_idx = (state_q == ICU_FILL) ? fill_idx : miss_idx;
            wr_tag = miss_tag;
            wr_data = (state_q == ICU_FILL) ? lf_word_in : pbus_data_in;
            wr_lock = 1'b0;
        end
    end

    icu_store #(.IDX_W(WIDX_W), .LW(LW), .TAG_W(TAG_W)) u_store (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .rd_idx_in(rd_idx),
        .we_in(we),
        .wr_idx_in(wr_idx),
        .wr_data_in(wr_data),
        .wr_tag_in(wr_tag),
        .wr_lock_in(wr_lock),
        .rd_data_out(rd_data),
        .rd_tag_out(rd_tag),
        .rd_valid_out(rd_valid),
        .rd_lock_out(rd_lock)
    );

    // ----------------------------------------
    // lookup and refill sequencing
    // ----------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_q <= ICU_IDLE;
            req_addr_q <= '0;
            first_q <= 1'b0;
            fill_cnt_q <= '0;
        end else begin
            first_q <= 1'b0;
            unique case (state_q)
                ICU_IDLE: begin
                    // non-cacheable fetches are left to the peripheral bus
                    if (fetch_valid_in && cacheable && !lookup_hit) begin
                        req_addr_q <= fetch_addr_in;
                        first_q <= 1'b1;
                        fill_cnt_q <= '0;
                        state_q <= `ICU_LINK_SEL ? ICU_FILL : ICU_BUS;
                    end
                end
                ICU_BUS: begin
                    if (first_q && fetch_abort_in) begin
                        state_q <= ICU_IDLE;
                    end else if (pbus_done_in) begin
                        state_q <= ICU_IDLE;
                    end
                end
                ICU_FILL: begin
                    if (first_q && fetch_abort_in) begin
                        state_q <= ICU_IDLE;
                    end else if (lf_word_valid_in) begin
                        fill_cnt_q <= fill_cnt_q + 3'h1;
                        if (fill_cnt_q == `ICU_FILL_WORDS - 3'h1) begin
                            state_q <= ICU_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // line request held until the first word of the burst arrives
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            lf_req_q <= 1'b0;
        end else if (state_q == ICU_IDLE) begin
            lf_req_q <= `ICU_LINK_SEL && fetch_valid_in && cacheable && !lookup_hit;
        end else if (lf_word_valid_in || (first_q && fetch_abort_in)) begin
            lf_req_q <= 1'b0;
        end
    end

    // ready pulse: a hit, or the critical word of a link fill
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            hit_ready_q <= 1'b0;
            instr_q <= '0;
        end else begin
            hit_ready_q <= 1'b0;
            if ((state_q == ICU_IDLE) && fetch_valid_in && cacheable && lookup_hit) begin
                hit_ready_q <= 1'b1;
                instr_q <= rd_data;
            end else if ((state_q == ICU_FILL) && lf_word_valid_in
                         && (fill_cnt_q == 3'h0)) begin
                hit_ready_q <= 1'b1;
                instr_q <= lf_word_in;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            hits_q <= '0;
        end else if (hit_ready_q) begin
            hits_q <= hits_q + 32'h1;
        end
    end

    assign hit_ready_out = hit_ready_q;
    assign instr_out = instr_q;
    assign lf_req_out = lf_req_q;
    assign lf_addr_out = req_addr_q;

    // ----------------------------------------
    // register bus slave
    // ----------------------------------------
    logic ph_take;
    logic bus_wr;

    assign ph_take = hsel_in && htrans_in[1] && hready_in;
    assign bus_wr = ph_sel_q && ph_write_q;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ph_sel_q <= 1'b0;
            ph_write_q <= 1'b0;
            ph_addr_q <= '0;
        end else if (hready_in) begin
            ph_sel_q <= ph_take;
            ph_write_q <= hwrite_in;
            ph_addr_q <= haddr_in[7:0];
        end
    end

    // move-to-special has priority over a bus write in the same cycle
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            msw_q <= `ICU_MSW_RST;
        end else if (move_to_special_wr_in) begin
            msw_q <= move_to_special_data_in;
        end else if (bus_wr && (ph_addr_q == `ICU_OFS_MSW)) begin
            msw_q <= hwdata_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            waddr_q <= '0;
            wdata_q <= '0;
        end else if (bus_wr && (ph_addr_q == `ICU_OFS_WADDR)) begin
            waddr_q <= hwdata_in;
        end else if (bus_wr && (ph_addr_q == `ICU_OFS_WDATA)) begin
            wdata_q <= hwdata_in;
        end
    end

    // the write op fires in the data phase of the command write
    assign op_go = bus_wr && (ph_addr_q == `ICU_OFS_WCMD)
                && hwdata_in[`ICU_CMD_GO_BIT];
    assign op_lock = hwdata_in[`ICU_CMD_LOCK_BIT];

    always_comb begin
        hrdata_out = '0;
        if (ph_sel_q && !ph_write_q) begin
            unique case (ph_addr_q)
                `ICU_OFS_MSW: hrdata_out = msw_q;
                `ICU_OFS_WADDR: hrdata_out = waddr_q;
                `ICU_OFS_WDATA: hrdata_out = wdata_q;
                `ICU_OFS_STATUS: hrdata_out = {29'h0, state_q};
                `ICU_OFS_HITS: hrdata_out = hits_q;
                default: hrdata_out = '0;
            endcase
        end
    end

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign machine_status_word_out = msw_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    logic req_idle;
    assign req_idle = fetch_valid_in && (state_q == ICU_IDLE);

    window_gate_a: assert property (
        req_idle && !in_window |=> !hit_ready_out
    ) else $error("hit outside cacheable window");
    noncache_idle_a: assert property (
        req_idle && !cacheable |=> (state_q == ICU_IDLE) && !lf_req_out
    ) else $error("non-cacheable fetch started cache action");
    hit_data_a: assert property (
        req_idle && cacheable && rd_valid && (rd_tag == req_tag)
        |=> hit_ready_out && (instr_out == $past(rd_data))
    ) else $error("hit missed or wrong word");
    miss_ready_a: assert property (
        req_idle && cacheable && !lookup_hit |=> !hit_ready_out && (state_q != ICU_IDLE)
    ) else $error("miss gave ready or did not wait");
    bus_refill_a: assert property (
        (state_q == ICU_BUS) && pbus_done_in && !rd_lock && !dbg_wr_in && !op_go
        |-> we && (wr_data == pbus_data_in)
    ) else $error("bus refill not stored");
    lock_keep_a: assert property (
        (state_q != ICU_IDLE) && rd_lock |-> !refill_we
    ) else $error("refill overwrote locked line");
    disabled_nohit_a: assert property (
        req_idle && !cache_en |=> !hit_ready_out ##1 !hit_ready_out
    ) else $error("disabled cache gave a hit");
    local_nocache_a: assert property (
        req_idle && in_local |=> (state_q == ICU_IDLE) && !hit_ready_out
    ) else $error("local fetch cached");
    abort_drop_a: assert property (
        (state_q != ICU_IDLE) && first_q && fetch_abort_in |=> state_q == ICU_IDLE
    ) else $error("abort not honoured");
    msw_read_a: assert property (
        ph_sel_q && !ph_write_q && (ph_addr_q == `ICU_OFS_MSW) |-> hrdata_out == msw_q
    ) else $error("status word read mismatch");
    sw_write_a: assert property (
        op_go && !dbg_wr_in |-> we && (wr_data == wdata_q)
    ) else $error("cache write op lost");

    hit_seen_c: cover property (req_idle && cacheable && lookup_hit);
    refill_seen_c: cover property ((state_q == ICU_BUS) ##[1:20] (state_q == ICU_IDLE));
    locked_miss_c: cover property ((state_q == ICU_BUS) && pbus_done_in && rd_lock);
    abort_seen_c: cover property (first_q && fetch_abort_in && (state_q != ICU_IDLE));
endmodule

/* hw/icu_cfg.svh */
`ifndef ICU_CFG_SVH
`define ICU_CFG_SVH

// ----------------------------------------
// build-time configuration
// ----------------------------------------
`define ICU_PRESENT 1'b1
`define ICU_LINK_SEL 1'b0
`define ICU_LOW_BOUND 32'h0030_0000
`define ICU_HIGH_BOUND 32'h0030_ffff
`define ICU_SPAN_W 16
`define ICU_WIDX_W 7
`define ICU_LOCAL_LOW 32'h0000_0000
`define ICU_LOCAL_HIGH 32'h0000_ffff
`define ICU_FILL_WORDS 3'h4

// ----------------------------------------
// register map and fields
// ----------------------------------------
`define ICU_OFS_MSW 8'h00
`define ICU_OFS_WADDR 8'h04
`define ICU_OFS_WDATA 8'h08
`define ICU_OFS_WCMD 8'h0c
`define ICU_OFS_STATUS 8'h10
`define ICU_OFS_HITS 8'h14
`define ICU_EN_BIT 26
`define ICU_CMD_GO_BIT 0
`define ICU_CMD_LOCK_BIT 1
`define ICU_MSW_RST 32'h0000_0000

`endif

/* hw/icu_pkg.sv */
package icu_pkg;
    typedef enum logic [2:0] {
        ICU_IDLE = 3'b001,
        ICU_BUS = 3'b010,
        ICU_FILL = 3'b100
    } icu_state_t;
    typedef logic [31:0] icu_word_t;
endpackage

/* hw/icu_store.sv */
`timescale 1ns/1ps
// ----------------------------------------
// flop-based tag, lock and instruction storage
// ----------------------------------------
module icu_store #(
    parameter int IDX_W = 7,
    parameter int LW = 0,
    parameter int TAG_W = 7
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [IDX_W-1:0] rd_idx_in,
    input wire logic we_in,
    input wire logic [IDX_W-1:0] wr_idx_in,
    input wire icu_pkg::icu_word_t wr_data_in,
    input wire logic [TAG_W-1:0] wr_tag_in,
    input wire logic wr_lock_in,
    output icu_pkg::icu_word_t rd_data_out,
    output logic [TAG_W-1:0] rd_tag_out,
    output logic rd_valid_out,
    output logic rd_lock_out
);
    import icu_pkg::*;
    localparam int NW = 1 << IDX_W;
    localparam int NL = 1 << (IDX_W - LW);

    icu_word_t data_q [NW];
    logic [TAG_W-1:0] tag_q [NL];
    logic [NL-1:0] valid_q;
    logic [NL-1:0] lock_q;
    logic [IDX_W-LW-1:0] rd_line;
    logic [IDX_W-LW-1:0] wr_line;

    assign rd_line = rd_idx_in[IDX_W-1:LW];
    assign wr_line = wr_idx_in[IDX_W-1:LW];

    // data words need no reset, the valid bit guards them
    always_ff @(posedge mclk_in) begin
        if (we_in) begin
            data_q[wr_idx_in] <= wr_data_in;
            tag_q[wr_line] <= wr_tag_in;
        end
    end

    // only reset clears lines; disabling the cache never does
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            valid_q <= '0;
            lock_q <= '0;
        end else if (we_in) begin
            valid_q[wr_line] <= 1'b1;
            lock_q[wr_line] <= wr_lock_in;
        end
    end

    assign rd_data_out = data_q[rd_idx_in];
    assign rd_tag_out = tag_q[rd_line];
    assign rd_valid_out = valid_q[rd_line];
    assign rd_lock_out = lock_q[rd_line];
endmodule

/* verif/icu_mem_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// peripheral bus instruction memory
// ----------------------------------------
module icu_mem_model (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic fetch_valid_in,
    input wire logic [31:0] fetch_addr_in,
    input wire logic fetch_abort_in,
    input wire logic [3:0] delay_in,
    output logic pbus_done_out,
    output icu_pkg::icu_word_t pbus_data_out
);
    import icu_pkg::*;
    logic busy_q;
    logic [3:0] cnt_q;
    logic [31:0] addr_q;

    // every fetch goes out speculatively, so the memory answers cacheable ones too
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            addr_q <= 32'h0;
            pbus_done_out <= 1'b0;
            pbus_data_out <= 32'h0;
        end else begin
            pbus_done_out <= 1'b0;
            // released data never repeats the last word
            pbus_data_out <= ~pbus_data_out;
            if (fetch_valid_in) begin
                busy_q <= 1'b1;
                cnt_q <= delay_in;
                addr_q <= fetch_addr_in;
            end else if (fetch_abort_in) begin
                busy_q <= 1'b0;
            end else if (busy_q && cnt_q == 4'h0) begin
                // one word per request on this bus
                busy_q <= 1'b0;
                pbus_done_out <= 1'b1;
                pbus_data_out <= {addr_q[15:0], ~addr_q[15:0]};
            end else if (busy_q) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule

/* verif/icu_top_tb.sv */
`timescale 1ns/1ps
`include "icu_cfg.svh"

`define CHK(nm, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("[ERR] %s expected %h seen %h", nm, exp, got); \
        end \
    end

module icu_top_tb;
    import icu_pkg::*;
    localparam icu_word_t EN = 32'h1 << `ICU_EN_BIT;
    localparam logic [31:0] A = `ICU_LOW_BOUND;
    localparam logic [31:0] C = `ICU_LOW_BOUND + 32'h10;
    logic mclk, rst, hsel, hwrite, fetch_valid, fetch_abort, dbg_wr, dbg_lock, mts_wr;
    logic [31:0] haddr, fetch_addr, dbg_addr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] mem_delay;
    icu_word_t hwdata, dbg_data, mts_data, hrdata, instr, pbus_data, msw, rd;
    logic hreadyout, hresp, hit_ready, pbus_done, lf_req;
    logic [31:0] lf_addr;
    logic [31:0] nc [3];
    int bad_count, total_checks, hit_cnt;

    icu_top dut (
        .mclk_in(mclk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
        .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
        .fetch_valid_in(fetch_valid), .fetch_addr_in(fetch_addr), .fetch_abort_in(fetch_abort),
        .hit_ready_out(hit_ready), .instr_out(instr), .pbus_done_in(pbus_done),
        .pbus_data_in(pbus_data), .lf_req_out(lf_req), .lf_addr_out(lf_addr),
        .lf_word_valid_in(1'b0),
        .lf_word_in(32'h0), .dbg_wr_in(dbg_wr), .dbg_addr_in(dbg_addr), .dbg_data_in(dbg_data),
        .dbg_lock_in(dbg_lock), .move_to_special_wr_in(mts_wr),
        .move_to_special_data_in(mts_data), .machine_status_word_out(msw)
    );

    icu_mem_model mem (
        .mclk_in(mclk), .rst_in(rst), .fetch_valid_in(fetch_valid), .fetch_addr_in(fetch_addr),
        .fetch_abort_in(fetch_abort), .delay_in(mem_delay), .pbus_done_out(pbus_done),
        .pbus_data_out(pbus_data)
    );

    // ----------------------------------------
    // clock and closing
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic finish_test();
        if (bad_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge mclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                `CHK("hready_wait", 1'b1, hreadyout)
                finish_test();
            end
            @(posedge mclk);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input icu_word_t d);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask

    task automatic rd_chk(input logic [7:0] a, input icu_word_t exp);
        ahb(1'b0, a, 32'h0);
        `CHK("reg_read", exp, rd)
    endtask

    task automatic move_to_special(input icu_word_t d);
        mts_data <= d;
        mts_wr <= 1'b1;
        @(posedge mclk);
        mts_wr <= 1'b0;
        @(posedge mclk);
        `CHK("status_word", d, msw)
    endtask

    // no hit: wait for the memory to finish, ready must stay low throughout
    task automatic fetch(input logic [31:0] a, input logic hit, input icu_word_t w);
        int n;
        fetch_addr <= a;
        fetch_valid <= 1'b1;
        @(posedge mclk);
        fetch_valid <= 1'b0;
        @(posedge mclk);
        `CHK("hit_ready", hit, hit_ready)
        if (hit) begin
            `CHK("instr", w, instr)
            hit_cnt++;
        end else begin
            n = 0;
            while (pbus_done !== 1'b1) begin
                @(posedge mclk);
                `CHK("miss_ready", 1'b0, hit_ready)
                n++;
                if (n > 40) begin
                    bad_count++;
                    finish_test();
                end
            end
            `CHK("lf_req", 1'b0, lf_req)
        end
    endtask

    function automatic icu_word_t mw(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {rst, hsel, hwrite, fetch_valid, fetch_abort, dbg_wr, dbg_lock, mts_wr} <= 8'hc0;
        {haddr, fetch_addr, dbg_addr, hwdata, dbg_data, mts_data} <= '0;
        htrans <= 2'b00;
        hsize <= 3'b010;
        mem_delay <= 4'h6;
        nc = '{`ICU_LOW_BOUND - 32'h4, `ICU_HIGH_BOUND + 32'h1, `ICU_LOCAL_LOW + 32'h100};
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd_chk(`ICU_OFS_MSW, `ICU_MSW_RST);
        rd_chk(`ICU_OFS_STATUS, {29'h0, ICU_IDLE});
        rd_chk(`ICU_OFS_HITS, 32'h0);
        rd_chk(8'h18, 32'h0);
        fetch(A, 1'b0, 0);
        move_to_special(EN);
        fetch(A, 1'b0, 0);
        fetch(A, 1'b1, mw(A));
        fetch(A + 32'h200, 1'b0, 0);
        fetch(A + 32'h200, 1'b1, mw(A + 32'h200));
        fetch(A, 1'b0, 0);
        fetch(A, 1'b1, mw(A));
        mem_delay <= 4'h0;
        foreach (nc[i]) begin
            fetch(nc[i], 1'b0, 0);
            fetch(nc[i], 1'b0, 0);
        end
        fetch(`ICU_HIGH_BOUND - 32'h3, 1'b0, 0);
        fetch(`ICU_HIGH_BOUND - 32'h3, 1'b1, mw(`ICU_HIGH_BOUND - 32'h3));
        mem_delay <= 4'h6;
        move_to_special(32'h0);
        fetch(A, 1'b0, 0);
        move_to_special(EN);
        fetch(A, 1'b1, mw(A));
        dbg_addr <= C;
        dbg_data <= 32'h1234_5678;
        dbg_lock <= 1'b1;
        dbg_wr <= 1'b1;
        @(posedge mclk);
        dbg_wr <= 1'b0;
        fetch(C, 1'b1, 32'h1234_5678);
        fetch(C + 32'h200, 1'b0, 0);
        fetch(C + 32'h200, 1'b0, 0);
        fetch(C, 1'b1, 32'h1234_5678);
        ahb(1'b1, `ICU_OFS_WADDR, A + 32'h20);
        ahb(1'b1, `ICU_OFS_WDATA, 32'h0bad_f00d);
        ahb(1'b1, `ICU_OFS_WCMD, 32'h1);
        fetch(A + 32'h20, 1'b1, 32'h0bad_f00d);
        rd_chk(`ICU_OFS_WADDR, A + 32'h20);
        fetch_addr <= A + 32'h40;
        fetch_valid <= 1'b1;
        @(posedge mclk);
        fetch_valid <= 1'b0;
        fetch_abort <= 1'b1;
        @(posedge mclk);
        fetch_abort <= 1'b0;
        repeat (3) @(posedge mclk);
        rd_chk(`ICU_OFS_STATUS, {29'h0, ICU_IDLE});
        fetch(A + 32'h40, 1'b0, 0);
        fetch(A + 32'h40, 1'b1, mw(A + 32'h40));
        `CHK("lf_addr", A + 32'h40, lf_addr)
        ahb(1'b1, `ICU_OFS_MSW, 32'h0);
        @(posedge mclk);
        `CHK("msw_ahb", 32'h0, msw)
        ahb(1'b1, `ICU_OFS_MSW, EN);
        rd_chk(`ICU_OFS_MSW, EN);
        rd_chk(`ICU_OFS_HITS, hit_cnt);
        finish_test();
    end
endmodule
